// ==== core/imt_pkg.sv ====
package imt_pkg;

  // ****************************************
  // table geometry and reset values
  // ****************************************
  localparam int TABLE_ENTRIES = 24;
  localparam int NUM_PORTS = 3;
  localparam logic [15:0] BURST_RESET = 16'h0600;
  localparam logic [15:0] RATE_RESET = 16'h0014;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_MAX = 32'hffff_ffff;

  // ****************************************
  // register numbers on the management port
  // ****************************************
  localparam logic [15:0] REG_CONFIG = 16'h184a;
  localparam logic [15:0] REG_COMMAND = 16'h184b;
  localparam logic [15:0] REG_STATUS = 16'h184c;
  localparam logic [15:0] REG_WDATA = 16'h184d;
  localparam logic [15:0] REG_RDATA = 16'h184e;
  localparam logic [15:0] REG_FCOUNT0 = 16'h1850;
  localparam logic [15:0] REG_FCOUNT1 = 16'h1851;
  localparam logic [15:0] REG_FCOUNT2 = 16'h1852;

  // ****************************************
  // field positions and reset values of fields
  // ****************************************
  localparam int CMD_RNW_BIT = 7;
  localparam int CMD_TYPE_LSB = 5;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_MODE_LSB = 1;
  localparam int STS_PEND_BIT = 0;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // ****************************************
  // timing
  // ****************************************
  localparam int RATE_UNIT_NS = 20;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CYCLES_PER_UNIT = (RATE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] ACCESS_WAIT = 2'h1;

  // ****************************************
  // codes
  // ****************************************
  typedef enum logic [1:0] {
    TYPE_RSVD = 2'h0, TYPE_RATE = 2'h1, TYPE_CBURST = 2'h2, TYPE_EBURST = 2'h3
  } imt_type_t;
  typedef enum logic [1:0] {
    MODE_PORT_PRI = 2'h0, MODE_PORT = 2'h1, MODE_PRI = 2'h2, MODE_RSVD = 2'h3
  } imt_mode_t;
  localparam logic [1:0] COLOR_GREEN = 2'h0;
  localparam logic [1:0] COLOR_YELLOW = 2'h1;
  localparam logic [1:0] COLOR_RED = 2'h2;

  // entry index of a flow under the selected rate mode
  function automatic logic [4:0] tableIndex(input imt_mode_t mode, input logic [1:0] port,
                                            input logic [2:0] pri);
    unique case (mode)
      MODE_PORT_PRI: tableIndex = {port, pri};
      MODE_PORT: tableIndex = {3'h0, port};
      MODE_PRI: tableIndex = {2'h0, pri};
      default: tableIndex = 5'h00;
    endcase
  endfunction

  // one token of refill; a level above the limit is left alone until spent below it
  function automatic logic [15:0] capBucket(input logic [15:0] level, input logic [15:0] limit);
    if (level >= limit) begin
      capBucket = level;
    end else begin
      capBucket = level + 16'h0001;
    end
  endfunction

endpackage

// ==== core/imt_filter_counter.sv ====
`timescale 1ns/100ps
module imt_filter_counter
  import imt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic countEvent,
  input wire logic readClear,
  output logic [31:0] count
);

  // ****************************************
  // saturating clear-on-read count
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= COUNT_RESET;
    end else if (readClear) begin
      count <= countEvent ? 32'h0000_0001 : COUNT_RESET;
    end else if (countEvent && count != COUNT_MAX) begin
      count <= count + 32'h0000_0001;
    end
  end

  count_sat_a: assert property (@(posedge clk) disable iff (!reset_n)
    count == COUNT_MAX && !readClear |=> count == COUNT_MAX)
    else $error("filter counter left its maximum");

  count_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    readClear && !countEvent |=> count == COUNT_RESET)
    else $error("filter counter not cleared by read");

endmodule // imt_filter_counter

// ==== core/imt_meter_table.sv ====
`timescale 1ns/100ps
module imt_meter_table
  import imt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wrEn,
  input imt_pkg::imt_type_t selType,
  input wire logic [4:0] selAddr,
  input wire logic [15:0] wrData,
  output logic [15:0] rdData,
  input wire logic [4:0] lookupIdx,
  output logic [15:0] lookupRate,
  output logic [15:0] committedBurst,
  output logic [15:0] excessBurst
);

  logic [15:0] rateEntry_q [TABLE_ENTRIES];
  wire addrOk = selAddr < 5'(TABLE_ENTRIES);
  wire lookupOk = lookupIdx < 5'(TABLE_ENTRIES);

  // ****************************************
  // indirect read selection and lookup
  // ****************************************
  assign rdData = (selType == TYPE_RATE && addrOk) ? rateEntry_q[selAddr] :
                  (selType == TYPE_CBURST) ? committedBurst :
                  (selType == TYPE_EBURST) ? excessBurst : DATA_RESET;
  assign lookupRate = lookupOk ? rateEntry_q[lookupIdx] : RATE_RESET;

  // storage of 24 rate entries and two burst sizes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < TABLE_ENTRIES; i++) begin
        rateEntry_q[i] <= RATE_RESET;
      end
      committedBurst <= BURST_RESET;
      excessBurst <= BURST_RESET;
    end else if (wrEn) begin
      if (selType == TYPE_RATE && addrOk) begin
        rateEntry_q[selAddr] <= wrData;
      end
      if (selType == TYPE_CBURST) begin
        committedBurst <= wrData;
      end
      if (selType == TYPE_EBURST) begin
        excessBurst <= wrData;
      end
    end
  end

  rsvd_type_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrEn && selType == TYPE_RSVD |=> $stable(committedBurst) && $stable(excessBurst))
    else $error("reserved table type changed a burst entry");

endmodule // imt_meter_table

// ==== core/imt_meter_access.sv ====
`timescale 1ns/100ps
module imt_meter_access
  import imt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regRdValid,
  input wire logic [2:0] filterDiscard,
  input wire logic pktValid,
  input wire logic [1:0] pktPort,
  input wire logic [2:0] pktPriority,
  input wire logic [15:0] pktLength,
  output logic [1:0] pktColor,
  output logic pktColorValid,
  output logic [15:0] committedLevel,
  output logic [15:0] excessLevel
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_WAIT = 3'b010, ST_DONE = 3'b100
  } imt_state_t;

  // ****************************************
  // state
  // ****************************************
  imt_state_t state_q, state_d;
  logic [1:0] waitCnt_q;
  logic [7:0] command_q;
  logic [2:0] config_q;
  logic [15:0] writeData_q;
  logic [15:0] readData_q;
  logic [4:0] flowIdx_q;
  logic [19:0] byteTimer_q;
  logic [15:0] tableRdData;
  logic [15:0] flowRate;
  logic [15:0] committedBurst;
  logic [15:0] excessBurst;
  logic [31:0] filterCount [NUM_PORTS];
  logic [31:0] readMux;

  // ****************************************
  // register decode
  // ****************************************
  wire isIdle = state_q == ST_IDLE;
  wire pending = !isIdle;
  wire wrConfig = regWrite && regAddr == REG_CONFIG;
  wire wrCommand = regWrite && regAddr == REG_COMMAND;
  wire wrWdata = regWrite && regAddr == REG_WDATA;
  wire cmdAccept = wrCommand && isIdle;
  wire cmdRead = command_q[CMD_RNW_BIT];
  wire [1:0] cmdTypeBits = command_q[CMD_TYPE_LSB +: 2];
  wire [4:0] cmdAddr = command_q[CMD_ADDR_LSB +: 5];
  wire imt_type_t cmdType = imt_type_t'(cmdTypeBits);
  wire tableWrite = state_q == ST_DONE && !cmdRead;
  wire tableCapture = state_q == ST_DONE && cmdRead;
  wire meterEnable = config_q[CFG_EN_BIT];
  wire [1:0] modeBits = config_q[CFG_MODE_LSB +: 2];
  wire imt_mode_t rateMode = imt_mode_t'(modeBits);
  wire [2:0] clearCount;

  // read data selection; reserved bits are zero
  assign readMux = (regAddr == REG_CONFIG) ? {29'h0, config_q} :
                   (regAddr == REG_COMMAND) ? {24'h0, command_q} :
                   (regAddr == REG_STATUS) ? {31'h0, pending} :
                   (regAddr == REG_WDATA) ? {16'h0, writeData_q} :
                   (regAddr == REG_RDATA) ? {16'h0, readData_q} :
                   (regAddr == REG_FCOUNT0) ? filterCount[0] :
                   (regAddr == REG_FCOUNT1) ? filterCount[1] :
                   (regAddr == REG_FCOUNT2) ? filterCount[2] : 32'h0000_0000;

  // a counter read clears the counter at the same edge that samples it
  assign clearCount[0] = regRead && regAddr == REG_FCOUNT0;
  assign clearCount[1] = regRead && regAddr == REG_FCOUNT1;
  assign clearCount[2] = regRead && regAddr == REG_FCOUNT2;

  // ****************************************
  // table and counters
  // ****************************************
  imt_meter_table table_i (
    .clk(clk),
    .reset_n(reset_n),
    .wrEn(tableWrite),
    .selType(cmdType),
    .selAddr(cmdAddr),
    .wrData(writeData_q),
    .rdData(tableRdData),
    .lookupIdx(flowIdx_q),
    .lookupRate(flowRate),
    .committedBurst(committedBurst),
    .excessBurst(excessBurst)
  );

  for (genvar p = 0; p < NUM_PORTS; p++) begin : gCount
    imt_filter_counter count_i (
      .clk(clk),
      .reset_n(reset_n),
      .countEvent(filterDiscard[p]),
      .readClear(clearCount[p]),
      .count(filterCount[p])
    );
  end

  // ****************************************
  // register bus flops
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regRdata <= 32'h0000_0000;
      regRdValid <= 1'b0;
    end else begin
      regRdata <= regRead ? readMux : regRdata;
      regRdValid <= regRead;
    end
  end

  // software registers; command write only taken when no access is running
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      config_q <= CFG_RESET;
      command_q <= CMD_RESET;
      writeData_q <= DATA_RESET;
    end else begin
      config_q <= wrConfig ? regWdata[2:0] : config_q;
      command_q <= cmdAccept ? regWdata[7:0] : command_q;
      writeData_q <= wrWdata ? regWdata[15:0] : writeData_q;
    end
  end

  // ****************************************
  // command sequencer
  // ****************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: state_d = cmdAccept ? ST_WAIT : ST_IDLE;
      ST_WAIT: state_d = (waitCnt_q == 2'h0) ? ST_DONE : ST_WAIT;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      waitCnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      waitCnt_q <= cmdAccept ? ACCESS_WAIT : (waitCnt_q - {1'b0, waitCnt_q != 2'h0});
    end
  end

  // read result capture
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readData_q <= DATA_RESET;
    end else if (tableCapture) begin
      readData_q <= tableRdData;
    end
  end

  // ****************************************
  // metering of arriving packets
  // ****************************************
  wire [16:0] rateUnits = {1'b0, flowRate} + 17'h0_0001;
  wire [19:0] rateInterval = 20'(rateUnits) * 20'(CYCLES_PER_UNIT);
  wire byteTick = byteTimer_q >= rateInterval - 20'h0_0001;
  wire meterPkt = pktValid && meterEnable;
  wire fitsCommitted = pktLength <= committedLevel;
  wire fitsExcess = pktLength <= excessLevel;
  wire [1:0] colorNext = !meterEnable ? COLOR_GREEN : fitsCommitted ? COLOR_GREEN :
                         fitsExcess ? COLOR_YELLOW : COLOR_RED;

  // one byte of credit per rate interval of the current flow
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      byteTimer_q <= 20'h0_0000;
      flowIdx_q <= 5'h00;
    end else begin
      byteTimer_q <= byteTick ? 20'h0_0000 : byteTimer_q + 20'h0_0001;
      flowIdx_q <= pktValid ? tableIndex(rateMode, pktPort, pktPriority) : flowIdx_q;
    end
  end

  // buckets start full at the default and refill only up to the programmed size
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      committedLevel <= BURST_RESET;
      excessLevel <= BURST_RESET;
    end else if (meterPkt && fitsCommitted) begin
      committedLevel <= committedLevel - pktLength;
    end else if (meterPkt && fitsExcess) begin
      excessLevel <= excessLevel - pktLength;
    end else if (byteTick) begin
      committedLevel <= capBucket(committedLevel, committedBurst);
      excessLevel <= capBucket(excessLevel, excessBurst);
    end
  end

  // colour result, one cycle after the packet
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pktColor <= COLOR_GREEN;
      pktColorValid <= 1'b0;
    end else begin
      pktColor <= pktValid ? colorNext : pktColor;
      pktColorValid <= pktValid;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence cmdIssue;
    cmdAccept;
  endsequence

  sequence cmdRuns;
    pending [*3] ##1 !pending;
  endsequence

  pend_cycle_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmdIssue |=> cmdRuns)
    else $error("pending flag did not run for three cycles");

  busy_ignore_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrCommand && pending |=> $stable(command_q))
    else $error("command changed while access pending");

  burst_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    tableWrite && cmdType == TYPE_CBURST |=> committedBurst == $past(writeData_q))
    else $error("committed burst not written from write data");

  read_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
    tableCapture |=> readData_q == $past(tableRdData))
    else $error("read data not captured at completion");

  upper_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    regRead && (regAddr == REG_STATUS || regAddr == REG_RDATA) |=> regRdata[31:16] == 16'h0)
    else $error("reserved upper bits read nonzero");

  mode_index_a: assert property (@(posedge clk) disable iff (!reset_n)
    pktValid && rateMode == MODE_PORT_PRI |=> flowIdx_q == {$past(pktPort), $past(pktPriority)})
    else $error("port and priority index wrong");

  mode_port_a: assert property (@(posedge clk) disable iff (!reset_n)
    pktValid && rateMode == MODE_PORT |=> flowIdx_q == {3'h0, $past(pktPort)})
    else $error("port only index wrong");

  mode_pri_a: assert property (@(posedge clk) disable iff (!reset_n)
    pktValid && rateMode == MODE_PRI |=> flowIdx_q == {2'h0, $past(pktPriority)})
    else $error("priority only index wrong");

  excess_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    tableWrite && cmdType == TYPE_EBURST |=> excessBurst == $past(writeData_q))
    else $error("excess burst not written from write data");

  bucket_reset_a: assert property (@(posedge clk)
    !reset_n |=> committedLevel == BURST_RESET && excessLevel == BURST_RESET)
    else $error("buckets not at default after reset");

  bucket_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
    byteTick && !meterPkt && committedLevel >= committedBurst |=> $stable(committedLevel))
    else $error("bucket above limit was changed by refill");

  red_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
    meterPkt && !fitsCommitted && !fitsExcess |=>
    pktColor == COLOR_RED && excessLevel >= $past(excessLevel))
    else $error("oversize packet not dropped");

  yellow_mark_a: assert property (@(posedge clk) disable iff (!reset_n)
    meterPkt && !fitsCommitted && fitsExcess |=> pktColor == COLOR_YELLOW)
    else $error("over committed packet not marked drop eligible");

  tick_space_a: assert property (@(posedge clk) disable iff (!reset_n)
    byteTick |=> !byteTick [*3])
    else $error("byte interval shorter than 20 ns");

endmodule // imt_meter_access

// ==== sim/imt_meter_access_tb_top.sv ====
`timescale 1ns/100ps
module imt_meter_access_tb_top;
  import imt_pkg::*;

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic [31:0] regRdata;
  logic regRdValid;
  logic [2:0] filterDiscard = 3'h0;
  logic pktValid = 1'b0;
  logic [1:0] pktPort = 2'h0;
  logic [2:0] pktPriority = 3'h0;
  logic [15:0] pktLength = 16'h0000;
  logic [1:0] pktColor;
  logic pktColorValid;
  logic [15:0] committedLevel;
  logic [15:0] excessLevel;
  int failures = 0;
  int checksDone = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  imt_meter_access i_imt_meter_access (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
    .filterDiscard(filterDiscard), .pktValid(pktValid), .pktPort(pktPort),
    .pktPriority(pktPriority), .pktLength(pktLength), .pktColor(pktColor),
    .pktColorValid(pktColorValid), .committedLevel(committedLevel), .excessLevel(excessLevel)
  );

  // ****************************************
  // reporting
  // ****************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************
  // register access
  // ****************************************
  task automatic do_reset(input int n);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (n) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // read data is taken one cycle after the strobe
  task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    check("read valid", 32'h1, {31'h0, regRdValid});
    d = regRdata;
  endtask

  task automatic rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    reg_rd(a, d);
    check(name, exp, d);
  endtask

  // launch a command, see it pending, then poll until it clears
  task automatic tbl_cmd(input logic [7:0] c);
    logic [31:0] s;
    int n;
    reg_wr(REG_COMMAND, {24'h0, c});
    reg_rd(REG_STATUS, s);
    check("pending", 32'h1, s);
    n = 0;
    while (s[STS_PEND_BIT] === 1'b1 && n < 10) begin
      reg_rd(REG_STATUS, s);
      n++;
    end
    check("status idle", 32'h0, s);
    if (s !== 32'h0) begin
      wrap_up();
    end
  endtask

  task automatic tbl_rd(input imt_type_t t, input logic [4:0] i, input logic [15:0] exp);
    tbl_cmd({1'b1, t, i});
    rd_chk("table entry", REG_RDATA, {16'h0, exp});
  endtask

  task automatic tbl_wr(input imt_type_t t, input logic [4:0] i, input logic [31:0] d);
    reg_wr(REG_WDATA, d);
    tbl_cmd({1'b0, t, i});
  endtask

  // ****************************************
  // packet and discard stimulus
  // ****************************************
  task automatic send_pkt(input logic [15:0] len, input logic [1:0] col,
                          input logic [15:0] expC, input logic [15:0] expE);
    @(posedge clk);
    pktValid <= 1'b1;
    pktPort <= 2'h1;
    pktPriority <= 3'h2;
    pktLength <= len;
    @(posedge clk);
    pktValid <= 1'b0;
    @(negedge clk);
    check("color valid", 32'h1, {31'h0, pktColorValid});
    check("color", {30'h0, col}, {30'h0, pktColor});
    check("committed level", {16'h0, expC}, {16'h0, committedLevel});
    check("excess level", {16'h0, expE}, {16'h0, excessLevel});
  endtask

  task automatic pulse_discard(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      filterDiscard <= m;
    end
    @(posedge clk);
    filterDiscard <= 3'h0;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    do_reset(20);
    // reset values and read-only or unmapped places
    rd_chk("status", REG_STATUS, 32'h0);
    rd_chk("write data", REG_WDATA, 32'h0);
    rd_chk("read data", REG_RDATA, 32'h0);
    for (int p = 0; p < NUM_PORTS; p++) begin
      rd_chk("counter", REG_FCOUNT0 + 16'(p), COUNT_RESET);
    end
    reg_wr(REG_STATUS, 32'hffff_ffff);
    reg_wr(16'h1853, 32'h1234_5678);
    rd_chk("status ro", REG_STATUS, 32'h0);
    rd_chk("unmapped", 16'h1853, 32'h0);
    check("levels", {BURST_RESET, BURST_RESET}, {committedLevel, excessLevel});
    $display("test reset done");
    // table defaults, writes of every type, out of range entry
    tbl_rd(TYPE_RATE, 5'd0, RATE_RESET);
    tbl_rd(TYPE_RATE, 5'd23, RATE_RESET);
    tbl_rd(TYPE_CBURST, 5'd0, BURST_RESET);
    tbl_rd(TYPE_EBURST, 5'd0, BURST_RESET);
    tbl_wr(TYPE_RATE, 5'd23, 32'hdead_1234);
    rd_chk("write data hi", REG_WDATA, 32'h0000_1234);
    tbl_rd(TYPE_RATE, 5'd23, 16'h1234);
    tbl_rd(TYPE_RATE, 5'd22, RATE_RESET);
    tbl_wr(TYPE_RATE, 5'd24, 32'h0000_5555);
    tbl_rd(TYPE_RATE, 5'd24, 16'h0000);
    tbl_wr(TYPE_CBURST, 5'd0, 32'h0000_0010);
    tbl_wr(TYPE_EBURST, 5'd0, 32'h0000_0580);
    tbl_wr(TYPE_RSVD, 5'd0, 32'h0000_7777);
    tbl_rd(TYPE_RSVD, 5'd0, 16'h0000);
    tbl_rd(TYPE_CBURST, 5'd0, 16'h0010);
    tbl_rd(TYPE_EBURST, 5'd0, 16'h0580);
    check("levels kept", {BURST_RESET, BURST_RESET}, {committedLevel, excessLevel});
    $display("test table done");
    // a write command issued while a read is pending is dropped
    reg_wr(REG_WDATA, 32'h0000_00aa);
    reg_wr(REG_COMMAND, {24'h0, 1'b1, TYPE_RATE, 5'd5});
    reg_wr(REG_COMMAND, {24'h0, 1'b0, TYPE_RATE, 5'd5});
    repeat (6) @(posedge clk);
    rd_chk("read data", REG_RDATA, {16'h0, RATE_RESET});
    tbl_rd(TYPE_RATE, 5'd5, RATE_RESET);
    rd_chk("read data holds", REG_RDATA, {16'h0, RATE_RESET});
    $display("test busy done");
    // rate modes held in the configuration register; a disabled packet in each is green
    tbl_wr(TYPE_RATE, 5'd10, 32'h0000_ffff);
    for (int m = 0; m < 3; m++) begin
      reg_wr(REG_CONFIG, 32'(m << CFG_MODE_LSB));
      rd_chk("mode", REG_CONFIG, 32'(m << CFG_MODE_LSB));
      send_pkt(16'd100, COLOR_GREEN, BURST_RESET, BURST_RESET);
    end
    // colouring: the slow rate of entry 10 keeps both buckets from refilling
    reg_wr(REG_CONFIG, 32'h1);
    send_pkt(16'h0100, COLOR_GREEN, 16'h0500, BURST_RESET);
    send_pkt(16'h0501, COLOR_YELLOW, 16'h0500, 16'h00ff);
    send_pkt(16'h0501, COLOR_RED, 16'h0500, 16'h00ff);
    send_pkt(16'h0500, COLOR_GREEN, 16'h0000, 16'h00ff);
    $display("test metering done");
    // filter counters: counts, clear on read, a discard at the clearing read
    for (int p = 0; p < NUM_PORTS; p++) begin
      pulse_discard(3'(1 << p), p + 2);
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      rd_chk("counter", REG_FCOUNT0 + 16'(p), 32'(p + 2));
      rd_chk("counter cleared", REG_FCOUNT0 + 16'(p), 32'h0);
    end
    pulse_discard(3'h1, 3);
    @(posedge clk);
    regAddr <= REG_FCOUNT0;
    regRead <= 1'b1;
    filterDiscard <= 3'h1;
    @(posedge clk);
    regRead <= 1'b0;
    filterDiscard <= 3'h0;
    @(negedge clk);
    check("counter old", 32'h3, regRdata);
    rd_chk("counter set", REG_FCOUNT0, 32'h1);
    $display("test counters done");
    // a second reset restores the table
    do_reset(2);
    tbl_rd(TYPE_RATE, 5'd23, RATE_RESET);
    tbl_rd(TYPE_CBURST, 5'd0, BURST_RESET);
    $display("test second reset done");
    wrap_up();
  end

endmodule // imt_meter_access_tb_top
